// >>> rtl/cspc_pkg.sv
package cspc_pkg;
  // Status bit positions
  localparam int StCarry = 0;
  localparam int StHalf = 1;
  localparam int StZero = 2;
  localparam int StSleep = 3;
  localparam int StWdog = 4;
  localparam int StSegLo = 5;
  localparam int StSegHi = 6;
  localparam int StSpare = 7;
  localparam logic [7:0] STATUS_ADDR = 8'h03;
  localparam logic [7:0] CNT_LOW_ADDR = 8'h02;
  localparam logic [2:0] STATUS_RST_HI = 3'h0;
  localparam logic [5:0] OPT_RST = 6'h3f;
  // Option field positions
  localparam int OptSrc = 5;
  localparam int OptEdge = 4;
  localparam int OptTarget = 3;

  typedef enum logic [3:0] {
    CSPC_OP_NONE = 4'h0,
    CSPC_OP_JUMP = 4'h1,
    CSPC_OP_CALL = 4'h2,
    CSPC_OP_COPY = 4'h3,
    CSPC_OP_ADD = 4'h4,
    CSPC_OP_SUB = 4'h5,
    CSPC_OP_BSET = 4'h6,
    CSPC_OP_ROR = 4'h7,
    CSPC_OP_ROL = 4'h8,
    CSPC_OP_LOGIC = 4'h9,
    CSPC_OP_OPTLD = 4'ha,
    CSPC_OP_KICK = 4'hb,
    CSPC_OP_SLEEP = 4'hc,
    CSPC_OP_RET = 4'hd
  } cspc_op_t;

  typedef struct packed {
    cspc_op_t op;
    logic [8:0] imm;
    logic [7:0] dest;
    logic toFile;
    logic [2:0] bitSel;
  } cspc_instr_t;

  typedef struct packed {
    logic timerSourceSelect;
    logic timerEdgeSelect;
    logic dividerTargetSelect;
    logic [2:0] dividerRatio;
  } cspc_opt_t;
endpackage

// >>> rtl/cspc_alu.sv
`timescale 1ns/10ps
module cspc_alu (
  input wire logic mclk,
  input wire logic rst,
  input wire cspc_pkg::cspc_op_t op,
  input wire logic [7:0] acc,
  input wire logic [7:0] fileVal,
  input wire logic [2:0] bitSel,
  input wire logic carryIn,
  output logic [7:0] result_r,
  output logic zero_r,
  output logic half_r,
  output logic carry_r,
  output logic flagZ_r,
  output logic flagHC_r
);
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] res;
  logic z, h, c, fz, fhc;

  // Subtraction as f + ~w + 1: carry out means no borrow
  always_comb begin
    sum = 9'h000;
    nib = 5'h00;
    res = fileVal;
    h = 1'b0;
    c = carryIn;
    fz = 1'b0;
    fhc = 1'b0;
    case (op)
      cspc_pkg::CSPC_OP_ADD: begin
        sum = {1'b0, fileVal} + {1'b0, acc};
        nib = {1'b0, fileVal[3:0]} + {1'b0, acc[3:0]};
        res = sum[7:0];
        h = nib[4];
        c = sum[8];
        fz = 1'b1;
        fhc = 1'b1;
      end
      cspc_pkg::CSPC_OP_SUB: begin
        sum = {1'b0, fileVal} + {1'b0, ~acc} + 9'h001;
        nib = {1'b0, fileVal[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
        res = sum[7:0];
        h = nib[4];
        c = sum[8];
        fz = 1'b1;
        fhc = 1'b1;
      end
      cspc_pkg::CSPC_OP_ROR: begin
        res = {carryIn, fileVal[7:1]};
        c = fileVal[0];
        fhc = 1'b0;
      end
      cspc_pkg::CSPC_OP_ROL: begin
        res = {fileVal[6:0], carryIn};
        c = fileVal[7];
      end
      cspc_pkg::CSPC_OP_COPY: res = acc;
      cspc_pkg::CSPC_OP_BSET: res = fileVal | (8'h01 << bitSel);
      cspc_pkg::CSPC_OP_LOGIC: begin
        res = acc | fileVal;
        fz = 1'b1;
      end
      default: res = fileVal;
    endcase
    z = (res == 8'h00);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      result_r <= 8'h00;
      zero_r <= 1'b0;
      half_r <= 1'b0;
      carry_r <= 1'b0;
      flagZ_r <= 1'b0;
      flagHC_r <= 1'b0;
    end else begin
      result_r <= res;
      zero_r <= z;
      half_r <= h;
      carry_r <= c;
      flagZ_r <= fz;
      flagHC_r <= fhc;
    end
  end
endmodule

// >>> rtl/cspc_core.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Six-bit write-only option register loads accumulator on option-load instruction.
// - Any reset sets all six option bits to one.
// - Option bits seven and six read zero.
// - Option bit five picks external pin or instruction clock for timer.
// - Option bit four picks falling (one) or rising (zero) pin edge.
// - Option bit three gives prescaler to watchdog (one) or timer (zero).
// - Ratio field divides timer by 2^(n+1), watchdog by 2^n.
// - Counter holds next address, increments each cycle unless loaded.
// - Jump loads counter bits eight to zero from instruction word.
// - Low counter byte register maps onto counter bits seven to zero.
// - Segment status bits supply counter bits nine and ten on jump, call and low-byte loads.
// - Call or low-byte write loads bits seven to zero, clears bit eight.
// - Copy, add and bit-set into low byte count as counter writes.
// - Flag-affecting instructions to status keep flag results, not data.
// - Watchdog-expiry and sleep flags ignore instruction writes.
// - Reset clears segment bits, preselecting page zero.
// - Reset loads counter with last address of last page.
//
// ALU instructions execute in two stages: the ALU registers its result, then write-back; jump, call, return and option load act in the first.
module cspc_core #(
  parameter int PcWidth = 11,
  parameter logic [10:0] ResetVector = 11'h7ff
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic powerOn,
  input wire logic wdogTimeout,
  input wire logic instrValid,
  input wire cspc_pkg::cspc_instr_t instr,
  input wire logic [7:0] acc,
  input wire logic [7:0] fileRdData,
  input wire logic [PcWidth-1:0] retAddr,
  output logic [PcWidth-1:0] progCounter_r,
  output logic [7:0] statusRd_r,
  output logic [7:0] counterLowRd_r,
  output logic [7:0] optionRd_r,
  output cspc_pkg::cspc_opt_t option_r,
  output logic [7:0] timerDivLog2_r,
  output logic [7:0] wdogDivLog2_r,
  output logic [7:0] fileWrData_r,
  output logic [7:0] fileWrAddr_r,
  output logic fileWrEn_r
);
  logic [7:0] status_r;
  logic [7:0] statusNxt;
  logic [PcWidth-1:0] pcNxt;
  cspc_pkg::cspc_instr_t ex_r;
  logic exValid_r;
  logic [7:0] aluRes;
  logic aluZ, aluH, aluC, aluFz, aluFhc;
  logic wrStatus, wrLow, isWrOp;

  // ALU sees raw file value; status/low byte come from their own holders
  cspc_alu u_alu (
    .mclk(mclk),
    .rst(rst),
    .op(instr.op),
    .acc(acc),
    .fileVal(instr.dest == cspc_pkg::STATUS_ADDR ? status_r :
             instr.dest == cspc_pkg::CNT_LOW_ADDR ? progCounter_r[7:0] : fileRdData),
    .bitSel(instr.bitSel),
    .carryIn(status_r[cspc_pkg::StCarry]),
    .result_r(aluRes),
    .zero_r(aluZ),
    .half_r(aluH),
    .carry_r(aluC),
    .flagZ_r(aluFz),
    .flagHC_r(aluFhc)
  );

  always_ff @(posedge mclk) begin
    if (rst) begin
      ex_r <= '0;
      exValid_r <= 1'b0;
    end else begin
      ex_r <= instr;
      exValid_r <= instrValid;
    end
  end

  always_comb begin
    isWrOp = 1'b0;
    case (ex_r.op)
      cspc_pkg::CSPC_OP_COPY, cspc_pkg::CSPC_OP_ADD, cspc_pkg::CSPC_OP_BSET:
        isWrOp = ex_r.toFile;
      cspc_pkg::CSPC_OP_SUB, cspc_pkg::CSPC_OP_ROR, cspc_pkg::CSPC_OP_ROL,
      cspc_pkg::CSPC_OP_LOGIC:
        isWrOp = ex_r.toFile;
      default: isWrOp = 1'b0;
    endcase
    wrStatus = exValid_r && isWrOp && ex_r.dest == cspc_pkg::STATUS_ADDR;
    wrLow = exValid_r && isWrOp && ex_r.dest == cspc_pkg::CNT_LOW_ADDR;
  end

  // Status next value
  always_comb begin
    statusNxt = status_r;
    if (wrStatus) begin
      statusNxt[7:5] = aluRes[7:5];
      statusNxt[cspc_pkg::StZero] = aluRes[cspc_pkg::StZero];
      statusNxt[cspc_pkg::StHalf] = aluRes[cspc_pkg::StHalf];
      statusNxt[cspc_pkg::StCarry] = aluRes[cspc_pkg::StCarry];
    end
    if (exValid_r) begin
      // Flag results override the data write to the same bits
      if (aluFz) statusNxt[cspc_pkg::StZero] = aluZ;
      if (aluFhc) statusNxt[cspc_pkg::StHalf] = aluH;
      if (ex_r.op == cspc_pkg::CSPC_OP_ADD || ex_r.op == cspc_pkg::CSPC_OP_SUB ||
          ex_r.op == cspc_pkg::CSPC_OP_ROR || ex_r.op == cspc_pkg::CSPC_OP_ROL)
        statusNxt[cspc_pkg::StCarry] = aluC;
    end
    // Expiry/sleep never taken from data; only events
    if (exValid_r && ex_r.op == cspc_pkg::CSPC_OP_KICK) begin
      statusNxt[cspc_pkg::StWdog] = 1'b1;
      statusNxt[cspc_pkg::StSleep] = 1'b1;
    end
    if (exValid_r && ex_r.op == cspc_pkg::CSPC_OP_SLEEP) begin
      statusNxt[cspc_pkg::StWdog] = 1'b1;
      statusNxt[cspc_pkg::StSleep] = 1'b0;
    end
    if (wdogTimeout) statusNxt[cspc_pkg::StWdog] = 1'b0;
  end

  // Over non-power-up resets sleep keeps its value; expiry keeps it unless wdogTimeout clears it
  always_ff @(posedge mclk) begin
    if (rst) begin
      status_r[7:5] <= cspc_pkg::STATUS_RST_HI;
      status_r[2:0] <= 3'h0;
      if (powerOn) begin
        status_r[cspc_pkg::StWdog] <= 1'b1;
        status_r[cspc_pkg::StSleep] <= 1'b1;
      end else if (wdogTimeout) begin
        status_r[cspc_pkg::StWdog] <= 1'b0;
      end
    end else begin
      status_r <= statusNxt;
    end
  end

  // Program counter
  always_comb begin
    pcNxt = progCounter_r + {{(PcWidth-1){1'b0}}, 1'b1};
    if (wrLow) begin
      pcNxt = progCounter_r;
      pcNxt[7:0] = aluRes;
      pcNxt[8] = 1'b0;
      if (PcWidth > 9) pcNxt[PcWidth-1:9] = status_r[5 +: PcWidth-9];
    end else if (instrValid && instr.op == cspc_pkg::CSPC_OP_JUMP) begin
      pcNxt = progCounter_r;
      pcNxt[8:0] = instr.imm;
      if (PcWidth > 9) pcNxt[PcWidth-1:9] = status_r[5 +: PcWidth-9];
    end else if (instrValid && instr.op == cspc_pkg::CSPC_OP_CALL) begin
      pcNxt = progCounter_r;
      pcNxt[7:0] = instr.imm[7:0];
      pcNxt[8] = 1'b0;
      if (PcWidth > 9) pcNxt[PcWidth-1:9] = status_r[5 +: PcWidth-9];
    end else if (instrValid && instr.op == cspc_pkg::CSPC_OP_RET) begin
      pcNxt = retAddr;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) progCounter_r <= ResetVector[PcWidth-1:0];
    else progCounter_r <= pcNxt;
  end

  // Option register
  always_ff @(posedge mclk) begin
    if (rst) option_r <= cspc_pkg::OPT_RST;
    else if (instrValid && instr.op == cspc_pkg::CSPC_OP_OPTLD)
      option_r <= acc[5:0];
  end

  // Divider exponents: timer n+1, watchdog n; other target gets none
  always_ff @(posedge mclk) begin
    if (rst) begin
      timerDivLog2_r <= 8'h00;
      wdogDivLog2_r <= 8'h00;
    end else begin
      timerDivLog2_r <= option_r.dividerTargetSelect ? 8'h00 :
                        {5'h00, option_r.dividerRatio} + 8'h01;
      wdogDivLog2_r <= option_r.dividerTargetSelect ?
                       {5'h00, option_r.dividerRatio} : 8'h00;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      // Read copies track their registers during reset too
      statusRd_r[7:5] <= cspc_pkg::STATUS_RST_HI;
      statusRd_r[cspc_pkg::StWdog] <= powerOn | (status_r[cspc_pkg::StWdog] & ~wdogTimeout);
      statusRd_r[cspc_pkg::StSleep] <= powerOn | status_r[cspc_pkg::StSleep];
      statusRd_r[2:0] <= 3'h0;
      counterLowRd_r <= ResetVector[7:0];
      optionRd_r <= {2'h0, cspc_pkg::OPT_RST};
      fileWrData_r <= 8'h00;
      fileWrAddr_r <= 8'h00;
      fileWrEn_r <= 1'b0;
    end else begin
      statusRd_r <= statusNxt;
      counterLowRd_r <= pcNxt[7:0];
      optionRd_r <= {2'h0, option_r};
      fileWrData_r <= aluRes;
      fileWrAddr_r <= ex_r.dest;
      fileWrEn_r <= exValid_r && isWrOp && !wrStatus && !wrLow;
    end
  end

  sequence s_page_load;
    wrLow || instrValid && (instr.op == cspc_pkg::CSPC_OP_JUMP ||
      instr.op == cspc_pkg::CSPC_OP_CALL);
  endsequence

  sequence s_bit8_clear;
    wrLow || instrValid && instr.op == cspc_pkg::CSPC_OP_CALL;
  endsequence

  a_opt_reset: assert property (@(posedge mclk)
    $fell(rst) |-> option_r == cspc_pkg::OPT_RST)
    else $error("option not all ones after reset");
  a_opt_upper: assert property (@(posedge mclk) disable iff (rst)
    optionRd_r[7:6] == 2'h0)
    else $error("option upper bits nonzero");
  a_pc_incr: assert property (@(posedge mclk) disable iff (rst)
    !instrValid && !wrLow ##1 !$past(rst) |-> progCounter_r == $past(progCounter_r) + 1'b1)
    else $error("counter did not increment");
  a_jump_load: assert property (@(posedge mclk) disable iff (rst)
    instrValid && instr.op == cspc_pkg::CSPC_OP_JUMP && !wrLow
    |=> progCounter_r[8:0] == $past(instr.imm))
    else $error("jump target wrong");
  a_call_bit8: assert property (@(posedge mclk) disable iff (rst)
    s_bit8_clear |=> !progCounter_r[8])
    else $error("counter bit eight not cleared");
  a_page_bits: assert property (@(posedge mclk) disable iff (rst)
    s_page_load |=> progCounter_r[10:9] == $past(status_r[6:5]))
    else $error("page bits wrong");
  a_reset_vec: assert property (@(posedge mclk)
    $fell(rst) |-> progCounter_r == ResetVector && status_r[6:5] == 2'h0)
    else $error("reset vector or segment wrong");
  a_sleep_flag: assert property (@(posedge mclk) disable iff (rst)
    exValid_r && ex_r.op == cspc_pkg::CSPC_OP_SLEEP |=> !status_r[cspc_pkg::StSleep])
    else $error("sleep flag not cleared");
  a_zero_flag: assert property (@(posedge mclk) disable iff (rst)
    exValid_r && aluFz |=> status_r[cspc_pkg::StZero] == ($past(aluRes) == 8'h00))
    else $error("zero flag wrong");
  a_flag_guard: assert property (@(posedge mclk) disable iff (rst)
    wrStatus && !wdogTimeout |=> $stable(status_r[4:3]))
    else $error("expiry or sleep flag took data");
endmodule

// >>> tb/cspc_file_model.sv
`timescale 1ns/10ps
module cspc_file_model (
  input wire logic mclk,
  input wire logic [7:0] rdAddr,
  input wire logic [7:0] statusRd,
  input wire logic [7:0] counterLowRd,
  input wire logic wrEn,
  input wire logic [7:0] wrAddr,
  input wire logic [7:0] wrData,
  output logic [7:0] rdData
);
  logic [7:0] mem [256];
  // Status and low counter byte live in the core, not here
  always_comb begin
    if (rdAddr == cspc_pkg::STATUS_ADDR) rdData = statusRd;
    else if (rdAddr == cspc_pkg::CNT_LOW_ADDR) rdData = counterLowRd;
    else rdData = mem[rdAddr];
  end
  always_ff @(posedge mclk) begin
    if (wrEn) mem[wrAddr] <= wrData;
  end
endmodule

// >>> tb/core_status_option_pc_bench.sv
`timescale 1ns/10ps
module core_status_option_pc_bench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic powerOn = 1'b1;
  logic wdogTimeout = 1'b0;
  logic instrValid = 1'b0;
  cspc_pkg::cspc_instr_t instr = '0;
  logic [7:0] acc = 8'h00;
  logic [7:0] fileRdData;
  logic [10:0] retAddr = 11'h000;
  logic [10:0] pc;
  logic [7:0] statusRd, lowRd, optRd, tDiv, wDiv, wrData, wrAddr;
  logic wrEn;
  cspc_pkg::cspc_opt_t opt;
  int err_count = 0;
  int samples_checked = 0;

  always #12.5 mclk = ~mclk;

  cspc_core i_dut (.mclk(mclk), .rst(rst), .powerOn(powerOn), .wdogTimeout(wdogTimeout),
    .instrValid(instrValid), .instr(instr), .acc(acc), .fileRdData(fileRdData),
    .retAddr(retAddr), .progCounter_r(pc), .statusRd_r(statusRd), .counterLowRd_r(lowRd),
    .optionRd_r(optRd), .option_r(opt), .timerDivLog2_r(tDiv), .wdogDivLog2_r(wDiv),
    .fileWrData_r(wrData), .fileWrAddr_r(wrAddr), .fileWrEn_r(wrEn));

  cspc_file_model i_file (.mclk(mclk), .rdAddr(instr.dest), .statusRd(statusRd),
    .counterLowRd(lowRd), .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData),
    .rdData(fileRdData));

  task automatic wrap_up();
    if (err_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pc(input logic [10:0] got, input logic [10:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: counter %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic issue(input cspc_pkg::cspc_op_t op, input logic [8:0] imm,
      input logic [7:0] dest, input logic [7:0] accv, input bit hold = 1'b0);
    instr = '{op: op, imm: imm, dest: dest, toFile: 1'b1, bitSel: 3'h5};
    acc = accv;
    instrValid = 1'b1;
    @(negedge mclk);
    // Held request lets the next call follow in the very next cycle
    if (!hold) begin
      instrValid = 1'b0;
      instr.op = cspc_pkg::CSPC_OP_NONE;
    end
  endtask

  // Counter keeps moving, so wait for the load to show, bounded
  task automatic wait_pc(input logic [10:0] exp, input logic [10:0] mask);
    int n;
    n = 0;
    while ((pc & mask) !== (exp & mask) && n < 6) begin
      @(negedge mclk);
      n++;
    end
    chk_pc(pc & mask, exp & mask);
  endtask

  task automatic wait_wr(input logic [7:0] d);
    int n;
    n = 0;
    while (wrEn !== 1'b1 && n < 6) begin
      @(negedge mclk);
      n++;
    end
    chk_byte(wrData, d);
    chk_byte(wrAddr, 8'h40);
    step(2);
  endtask

  task automatic t_reset();
    rst = 1'b1;
    step(12);
    chk_pc(pc, 11'h7ff);
    chk_byte(optRd, 8'h3f);
    chk_byte({2'b00, opt}, 8'h3f);
    chk_byte(statusRd & 8'hf8, 8'h18);
    chk_byte(lowRd, 8'hff);
    rst = 1'b0;
    // Later resets are not power-up: flags must be kept
    powerOn = 1'b0;
    wait_pc(11'h000, 11'h7ff);
    step(1);
    chk_pc(pc, 11'h001);
  endtask

  task automatic t_option();
    logic s;
    for (int t = 0; t < 2; t++) begin
      for (int r = 0; r < 8; r++) begin
        s = r[0];
        // Upper bits set on purpose: they must not stick
        issue(cspc_pkg::CSPC_OP_OPTLD, 9'h000, 8'h00, {2'h3, s, ~s, t[0], r[2:0]});
        step(3);
        chk_byte(optRd, {2'b00, s, ~s, t[0], r[2:0]});
        chk_byte({5'h00, opt.timerSourceSelect, opt.timerEdgeSelect,
          opt.dividerTargetSelect}, {5'h00, s, ~s, t[0]});
        chk_byte(tDiv, t[0] ? 8'h00 : 8'(r + 1));
        chk_byte(wDiv, t[0] ? 8'(r) : 8'h00);
      end
    end
  endtask

  task automatic t_status();
    issue(cspc_pkg::CSPC_OP_COPY, 9'h000, cspc_pkg::STATUS_ADDR, 8'hff);
    step(3);
    chk_byte(statusRd, 8'hff);
    issue(cspc_pkg::CSPC_OP_COPY, 9'h000, cspc_pkg::STATUS_ADDR, 8'h00);
    step(3);
    chk_byte(statusRd, 8'h18);
    // 18 + e8 wraps to zero with both carries
    issue(cspc_pkg::CSPC_OP_ADD, 9'h000, cspc_pkg::STATUS_ADDR, 8'he8);
    step(3);
    chk_byte(statusRd, 8'h1f);
  endtask

  task automatic t_paging();
    issue(cspc_pkg::CSPC_OP_COPY, 9'h000, cspc_pkg::STATUS_ADDR, 8'h60);
    step(3);
    issue(cspc_pkg::CSPC_OP_JUMP, 9'h155, 8'h00, 8'h00);
    wait_pc(11'h755, 11'h7ff);
    issue(cspc_pkg::CSPC_OP_CALL, 9'h1a4, 8'h00, 8'h00);
    wait_pc(11'h6a4, 11'h7ff);
    issue(cspc_pkg::CSPC_OP_COPY, 9'h000, cspc_pkg::STATUS_ADDR, 8'h20);
    step(3);
    issue(cspc_pkg::CSPC_OP_COPY, 9'h000, cspc_pkg::CNT_LOW_ADDR, 8'h3c);
    wait_pc(11'h23c, 11'h7ff);
    chk_byte(lowRd, 8'h3c);
    issue(cspc_pkg::CSPC_OP_JUMP, 9'h1c0, 8'h00, 8'h00, 1'b1);
    issue(cspc_pkg::CSPC_OP_BSET, 9'h000, cspc_pkg::CNT_LOW_ADDR, 8'h00);
    wait_pc(11'h2e0, 11'h7ff);
    retAddr = 11'h5a5;
    issue(cspc_pkg::CSPC_OP_RET, 9'h000, 8'h00, 8'h00);
    wait_pc(11'h5a5, 11'h7ff);
  endtask

  task automatic t_flags();
    issue(cspc_pkg::CSPC_OP_COPY, 9'h000, 8'h40, 8'h10);
    wait_wr(8'h10);
    issue(cspc_pkg::CSPC_OP_SUB, 9'h000, 8'h40, 8'h01);
    wait_wr(8'h0f);
    chk_byte(statusRd & 8'h07, 8'h01);
    issue(cspc_pkg::CSPC_OP_COPY, 9'h000, 8'h40, 8'h02);
    wait_wr(8'h02);
    issue(cspc_pkg::CSPC_OP_ROR, 9'h000, 8'h40, 8'h00);
    wait_wr(8'h81);
    chk_byte(statusRd & 8'h01, 8'h00);
    issue(cspc_pkg::CSPC_OP_ROL, 9'h000, 8'h40, 8'h00);
    wait_wr(8'h02);
    chk_byte(statusRd & 8'h01, 8'h01);
    issue(cspc_pkg::CSPC_OP_COPY, 9'h000, 8'h40, 8'h00);
    wait_wr(8'h00);
    issue(cspc_pkg::CSPC_OP_LOGIC, 9'h000, 8'h40, 8'h00);
    wait_wr(8'h00);
    chk_byte(statusRd & 8'h04, 8'h04);
  endtask

  task automatic t_events();
    issue(cspc_pkg::CSPC_OP_SLEEP, 9'h000, 8'h00, 8'h00);
    step(3);
    chk_byte(statusRd & 8'h18, 8'h10);
    wdogTimeout = 1'b1;
    step(1);
    wdogTimeout = 1'b0;
    step(2);
    chk_byte(statusRd & 8'h18, 8'h00);
    issue(cspc_pkg::CSPC_OP_KICK, 9'h000, 8'h00, 8'h00);
    step(3);
    chk_byte(statusRd & 8'h18, 8'h18);
  endtask

  initial begin
    t_reset();
    t_option();
    t_status();
    t_paging();
    t_flags();
    t_events();
    // Second reset after the option and segment bits were changed
    t_reset();
    wrap_up();
  end

  initial begin
    repeat (3000) @(posedge mclk);
    err_count++;
    wrap_up();
  end
endmodule
